// [design/omed_pkg.sv]
package omed_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ORIENT_STATUS = 8'h10;
	localparam logic [7:0] IDX_ORIENT_CFG    = 8'h11;
	localparam logic [7:0] IDX_ORIENT_DBNC   = 8'h12;
	localparam logic [7:0] IDX_BF_TILT       = 8'h13;
	localparam logic [7:0] IDX_TRIP_THS      = 8'h14;
	localparam logic [7:0] IDX_MOTION_CFG    = 8'h15;
	localparam logic [7:0] IDX_MOTION_SRC    = 8'h16;
	localparam logic [7:0] IDX_MOTION_CNT    = 8'h18;

	// orientation_config fields
	localparam int CFG_CLEAR_MODE_BIT = 7;
	localparam int CFG_ENABLE_BIT     = 6;
	localparam logic [7:0] ORIENT_CFG_RESET = 8'h80;
	localparam logic [7:0] ORIENT_DBNC_RESET = 8'h00;

	// motion config fields
	localparam int MCFG_LATCH_BIT  = 7;
	localparam int MCFG_SELECT_BIT = 6;
	localparam int MCFG_EN_LSB     = 3;
	localparam logic [7:0] MOTION_CFG_RESET = 8'h00;
	localparam logic [7:0] MOTION_CNT_RESET = 8'h00;

	// Fixed read-only angle codes
	localparam logic [1:0] BACK_FRONT_CODE  = 2'h1;
	localparam logic [2:0] Z_LOCK_CODE      = 3'h4;
	localparam logic [4:0] TRIP_ANGLE_CODE  = 5'h10;
	localparam logic [2:0] MARGIN_CODE      = 3'h4;

	// Debounce time step per sample, in microseconds
	localparam int STEP_FASTEST_US = 1250;
	localparam int STEP_HIGHRES_US = 2500;
	localparam int STEP_LOWPWR_US  = 160000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic       latch;
		logic       motion;
		logic [2:0] axis_en;
	} omed_mcfg_s;

	typedef struct packed {
		logic       lockout;
		logic [1:0] landscape;
		logic       back;
	} omed_orient_s;
endpackage : omed_pkg

// [design/omed_event_detect.sv]
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module omed_event_detect
	import omed_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	input  wire logic        sample_tick,
	input  wire logic        sleep_state,
	input  wire logic [3:0]  orient_pos,
	input  wire logic [2:0]  axis_high,
	input  wire logic [2:0]  axis_pol,
	output var  logic        orient_event,
	output var  logic        motion_event
);
	logic [7:0]   orient_cfg;
	logic [7:0]   orient_dbnc;
	logic [7:0]   motion_cfg;
	logic [7:0]   motion_cnt;
	logic [7:0]   wr_idx;
	logic         wr_pend;
	logic [7:0]   ocnt;
	logic         first_pend;
	logic         sleep_q;
	omed_orient_s orient_cur;
	logic [7:0]   mcnt;
	logic [2:0]   high_flag;
	logic [2:0]   pol_flag;

	function automatic logic [7:0] pick_byte(input logic [7:0] idx,
		input logic [7:0] os, input logic [7:0] ms);
		unique case (idx)
			IDX_ORIENT_STATUS: pick_byte = os;
			IDX_ORIENT_CFG:    pick_byte = orient_cfg;
			IDX_ORIENT_DBNC:   pick_byte = orient_dbnc;
			IDX_BF_TILT:       pick_byte = {BACK_FRONT_CODE, 3'h0, Z_LOCK_CODE};
			IDX_TRIP_THS:      pick_byte = {TRIP_ANGLE_CODE, MARGIN_CODE};
			IDX_MOTION_CFG:    pick_byte = motion_cfg;
			IDX_MOTION_SRC:    pick_byte = ms;
			IDX_MOTION_CNT:    pick_byte = motion_cnt;
			default:           pick_byte = 8'h00;
		endcase
	endfunction : pick_byte

	// Bus decode; a read answers in its data phase with no wait state
	wire        take      = hsel & hready & htrans[1];
	wire [7:0]  idx       = haddr[9:2];
	wire        rd_take   = take & ~hwrite;
	wire        wr_take   = take & hwrite;
	wire        status_rd = rd_take & (idx == IDX_ORIENT_STATUS);
	wire        src_rd    = rd_take & (idx == IDX_MOTION_SRC);
	wire        wr_now    = wr_pend;
	wire [7:0]  wbyte     = hwdata[7:0];

	wire        clear_mode = orient_cfg[CFG_CLEAR_MODE_BIT];
	wire        orient_on  = orient_cfg[CFG_ENABLE_BIT];
	omed_mcfg_s mcfg;
	assign mcfg = omed_mcfg_s'({motion_cfg[7:6], motion_cfg[5:3]});

	// Orientation debounce; each sample tick is one time step
	wire        otick      = orient_on & sample_tick;
	wire        sleep_edge = sleep_q != sleep_state;
	wire        differs    = first_pend | (orient_pos != orient_cur);
	wire        o_update   = otick & differs & (ocnt >= orient_dbnc);
	logic [7:0] next_ocnt;
	always_comb
	begin
		next_ocnt = ocnt;
		if (sleep_edge | ~orient_on)
			next_ocnt = 8'h00;
		else if (otick & differs)
			next_ocnt = o_update ? 8'h00 : ocnt + 8'h01;
		else if (otick)
			next_ocnt = (clear_mode | ocnt == 8'h00) ? 8'h00 : ocnt - 8'h01;
	end

	// Change flag: a new orientation in the read cycle still sets it
	wire next_oflag = o_update | (orient_event & ~status_rd);
	wire [7:0] ostat = {orient_event, orient_cur.lockout, 3'h0,
		orient_cur.landscape, orient_cur.back};

	// Freefall/motion condition over enabled axes only
	wire [2:0] hi_en   = axis_high & mcfg.axis_en;
	wire       m_act   = |mcfg.axis_en;
	wire       m_cond  = mcfg.motion ? |hi_en : (hi_en == 3'h0);
	wire       mtick   = m_act & sample_tick;
	wire       reached = mtick & m_cond & (mcnt >= motion_cnt);
	wire       m_hold  = mcfg.latch & motion_event;
	wire       lat_rd  = src_rd & mcfg.latch;
	logic       next_ea;
	logic [7:0] next_mcnt;
	always_comb
	begin
		next_ea = motion_event;
		next_mcnt = mcnt;
		if (~m_act)
		begin
			next_ea = 1'b0;
			next_mcnt = 8'h00;
		end
		else if (reached)
			next_ea = 1'b1;
		else if (lat_rd)
		begin
			// A read must restart the count, so no tick may add to it here
			next_ea = 1'b0;
			next_mcnt = 8'h00;
		end
		else if (mtick & m_cond)
			next_mcnt = mcnt + 8'h01;
		else if (mtick)
		begin
			if (clear_mode)
			begin
				next_mcnt = 8'h00;
				if (~mcfg.latch)
					next_ea = 1'b0;
			end
			else if (mcnt != 8'h00)
				next_mcnt = mcnt - 8'h01;
			else if (~mcfg.latch)
				next_ea = 1'b0;
		end
	end

	wire [7:0] msrc = {motion_event, 1'b0, high_flag[2], pol_flag[2],
		high_flag[1], pol_flag[1], high_flag[0], pol_flag[0]};
	wire [7:0] rd_byte = pick_byte(idx, ostat, msrc);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata    <= 32'h0;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_idx    <= 8'h00;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= wr_take;
			wr_idx    <= idx;
			hrdata    <= rd_take ? {24'h0, rd_byte} : 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			orient_cfg  <= ORIENT_CFG_RESET;
			orient_dbnc <= ORIENT_DBNC_RESET;
			motion_cfg  <= MOTION_CFG_RESET;
			motion_cnt  <= MOTION_CNT_RESET;
		end
		else if (wr_now)
		begin
			if (wr_idx == IDX_ORIENT_CFG)
				orient_cfg <= {wbyte[7:6], 6'h00};
			if (wr_idx == IDX_ORIENT_DBNC)
				orient_dbnc <= wbyte;
			if (wr_idx == IDX_MOTION_CFG)
				motion_cfg <= {wbyte[7:3], 3'h0};
			if (wr_idx == IDX_MOTION_CNT)
				motion_cnt <= wbyte;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ocnt         <= 8'h00;
			first_pend   <= 1'b1;
			sleep_q      <= 1'b0;
			orient_cur   <= '0;
			orient_event <= 1'b0;
		end
		else
		begin
			ocnt         <= next_ocnt;
			sleep_q      <= sleep_state;
			orient_event <= next_oflag;
			// Re-arm the first report whenever detection is switched off
			first_pend   <= ~orient_on | (first_pend & ~o_update);
			if (o_update)
				orient_cur <= orient_pos;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mcnt         <= 8'h00;
			motion_event <= 1'b0;
		end
		else
		begin
			mcnt         <= next_mcnt;
			motion_event <= next_ea;
		end
	end

	// Axis flags; frozen while a latched event waits for its read
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_axis
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					high_flag[g] <= 1'b0;
					pol_flag[g]  <= 1'b0;
				end
				else if (lat_rd & mcfg.motion & m_hold)
				begin
					high_flag[g] <= 1'b0;
					pol_flag[g]  <= 1'b0;
				end
				else if (~m_hold | lat_rd)
				begin
					high_flag[g] <= hi_en[g];
					pol_flag[g]  <= axis_pol[g] & mcfg.axis_en[g];
				end
			end
		end
	endgenerate

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_lat_set;
		mcfg.latch && motion_event;
	endsequence

	a_orient_off_idle: assert property (!orient_on |=> ocnt == 8'h00)
		else $error("orientation counter ran while disabled");
	a_clear_mode_cnt: assert property (otick && !differs && clear_mode && !sleep_edge
		|=> ocnt == 8'h00)
		else $error("clear mode did not clear counter");
	a_sleep_resets: assert property (sleep_edge |=> ocnt == 8'h00)
		else $error("power state change kept counter");
	a_fixed_angles: assert property (rd_take && idx == IDX_BF_TILT
		|=> hrdata == 32'h00000044)
		else $error("tilt register code wrong");
	a_fixed_trip: assert property (rd_take && idx == IDX_TRIP_THS
		|=> hrdata == 32'h00000084)
		else $error("trip register code wrong");
	a_no_axes_idle: assert property (!m_act |=> !motion_event)
		else $error("event with all axes off");
	a_latch_holds: assert property (s_lat_set and !src_rd and m_act
		|=> motion_event)
		else $error("latched event dropped without read");
	a_read_clears: assert property (s_lat_set and src_rd and !reached
		|=> !motion_event && mcnt == 8'h00)
		else $error("source read did not clear latched event");
	a_unlatched_rd: assert property (src_rd && !mcfg.latch && motion_event
		&& !sample_tick && m_act |=> motion_event)
		else $error("unlatched read changed flag");
	a_motion_drop: assert property (!mcfg.latch && mcfg.motion && clear_mode
		&& mtick && !m_cond |=> !motion_event)
		else $error("flag kept after condition left");
	a_axis_frozen: assert property (s_lat_set and !src_rd |=> $stable(high_flag))
		else $error("axis flags moved while latched");
	a_motion_rd_clr: assert property (s_lat_set and src_rd and mcfg.motion
		|=> high_flag == 3'h0)
		else $error("latched motion read left axis flags");
	a_change_flag: assert property (o_update |=> orient_event [*1] ##0 ocnt == 8'h00)
		else $error("change flag not set on new orientation");
	a_status_rd_clr: assert property (status_rd && !o_update
		|=> !orient_event)
		else $error("status read did not clear change flag");
	a_dec_delay: assert property (!mcfg.latch && !clear_mode && motion_event
		&& mtick && !m_cond && mcnt != 8'h00 |=> motion_event)
		else $error("decrement mode dropped flag early");
endmodule : omed_event_detect
`default_nettype wire

// [verification/omed_event_detect_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module omed_event_detect_tb;
	import omed_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, sample_tick, sleep_state;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [3:0]  orient_pos, pos;
	logic [2:0]  axis_high, axis_pol, pol;
	logic        orient_event, motion_event;
	logic [7:0]  cnt, d;
	int          n_errors, n_compared;

	omed_event_detect omed_event_detect_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.sample_tick(sample_tick), .sleep_state(sleep_state), .orient_pos(orient_pos),
		.axis_high(axis_high), .axis_pol(axis_pol), .orient_event(orient_event),
		.motion_event(motion_event));

	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	function automatic logic [31:0] src_exp(input logic ev, input logic [2:0] h, p);
		return {24'h0, ev, 1'b0, h[2], p[2], h[1], p[1], h[0], p[0]};
	endfunction : src_exp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Waits on hreadyout even though it never drops, so a stalled slave is caught
	task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(hresp, 32'h0);
	endtask : ahb

	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		ahb(1'b0, idx, 8'h00);
		chk(rd, exp);
	endtask : rchk

	task automatic tick(input int n);
		repeat (n)
		begin
			sample_tick <= 1'b1;
			@(posedge hclk);
			sample_tick <= 1'b0;
			@(posedge hclk);
		end
		repeat (3) @(posedge hclk);
	endtask : tick

	task automatic summarize;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (40000) @(posedge hclk);
		n_errors++;
		summarize();
	end

	initial
	begin
		{hresetn, hsel, hwrite, sample_tick, sleep_state} = '0;
		{haddr, hwdata, htrans, orient_pos, axis_high, axis_pol} = '0;
		void'($urandom(354));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(IDX_ORIENT_CFG, 32'h80);
		rchk(IDX_ORIENT_DBNC, 32'h00);
		for (int i = 0; i < 2; i++)
		begin
			d = $urandom;
			ahb(1'b1, IDX_BF_TILT, d);
			ahb(1'b1, IDX_TRIP_THS, d);
			rchk(IDX_BF_TILT, 32'h44);
			rchk(IDX_TRIP_THS, 32'h84);
			ahb(1'b1, IDX_ORIENT_CFG, d);
			rchk(IDX_ORIENT_CFG, {24'h0, d & 8'hc0});
			ahb(1'b1, IDX_ORIENT_DBNC, d);
			rchk(IDX_ORIENT_DBNC, {24'h0, d});
			rchk(8'h3f, 32'h0);
		end
		$display("registers done");
		pos = $urandom;
		cnt = 8'h1 + 8'($urandom % 3);
		orient_pos <= pos;
		ahb(1'b1, IDX_ORIENT_CFG, 8'h80);
		ahb(1'b1, IDX_ORIENT_DBNC, cnt);
		tick(6);
		chk(orient_event, 1'b0);
		ahb(1'b1, IDX_ORIENT_CFG, 8'hc0);
		tick(cnt);
		chk(orient_event, 1'b0);
		tick(1);
		chk(orient_event, 1'b1);
		rchk(IDX_ORIENT_STATUS, {24'h0, 1'b1, pos[3], 3'b000, pos[2:0]});
		chk(orient_event, 1'b0);
		orient_pos <= pos ^ 4'h1;
		tick(cnt);
		sleep_state <= 1'b1;
		@(posedge hclk);
		tick(cnt);
		chk(orient_event, 1'b0);
		tick(1);
		chk(orient_event, 1'b1);
		$display("orientation done");
		pol = $urandom;
		axis_high <= 3'b001;
		axis_pol  <= pol & 3'b001;
		ahb(1'b1, IDX_MOTION_CNT, cnt);
		ahb(1'b1, IDX_MOTION_CFG, 8'hf8);
		tick(cnt);
		chk(motion_event, 1'b0);
		tick(1);
		chk(motion_event, 1'b1);
		axis_high <= 3'b000;
		tick(1);
		rchk(IDX_MOTION_SRC, src_exp(1'b1, 3'b001, pol & 3'b001));
		chk(motion_event, 1'b0);
		rchk(IDX_MOTION_SRC, 32'h0);
		$display("latched motion done");
		axis_high <= 3'b010;
		axis_pol  <= pol & 3'b010;
		ahb(1'b1, IDX_MOTION_CFG, 8'h78);
		tick(cnt + 1);
		rchk(IDX_MOTION_SRC, src_exp(1'b1, 3'b010, pol & 3'b010));
		chk(motion_event, 1'b1);
		axis_high <= 3'b000;
		tick(1);
		chk(motion_event, 1'b0);
		$display("unlatched motion done");
		axis_high <= 3'b110;
		axis_pol  <= 3'b000;
		ahb(1'b1, IDX_MOTION_CFG, 8'h08);
		tick(cnt + 1);
		chk(motion_event, 1'b1);
		rchk(IDX_MOTION_SRC, 32'h80);
		axis_high <= 3'b111;
		tick(1);
		chk(motion_event, 1'b0);
		ahb(1'b1, IDX_MOTION_CFG, 8'h00);
		axis_high <= 3'b000;
		tick(cnt + 2);
		chk(motion_event, 1'b0);
		$display("freefall done");
		summarize();
	end
endmodule : omed_event_detect_tb
`default_nettype wire
